/* File: design/pin_select_pkg.sv */
// constants and carrier types for the general pin function selector
package pin_select_pkg;
    localparam int PIN_COUNT = 16;
    localparam int CODE_W = 4;
    localparam int ADC_W = 12;

    localparam logic [3:0] FN_DISABLE = 4'h0;
    localparam logic [3:0] FN_MAIN = 4'h1;
    localparam logic [3:0] FN_ANALOG = 4'h2;
    localparam logic [3:0] FN_FLOAT = 4'h3;
    localparam logic [3:0] FN_PULLUP = 4'h4;
    localparam logic [3:0] FN_PULLDOWN = 4'h5;
    localparam logic [3:0] FN_LOW = 4'h6;
    localparam logic [3:0] FN_HIGH = 4'h7;
    localparam logic [3:0] FN_IND_TRUE = 4'h8; // low while condition holds
    localparam logic [3:0] FN_IND_INV = 4'h9;

    // per-pin capability masks, bit n is pin n
    // pin 10 main carries the slave select shared with sleep request
    localparam logic [15:0] CAP_MAIN = 16'h67FF;
    localparam logic [15:0] CAP_ANALOG = 16'h1803;
    localparam logic [15:0] CAP_FLOAT = 16'hFCFF;
    localparam logic [15:0] CAP_PULLUP = 16'hE7FC;
    localparam logic [15:0] CAP_IND = 16'h183F;
    // main function drives pin (others are inputs to the device; pins 2 to 5 go by the master/slave role)
    localparam logic [15:0] MAIN_DRIVES = 16'h40A7;

    // reset codes: pulled-up where possible, else fixed level
    localparam logic [3:0] RST_NO_PULL = 4'h6;

    // analog channel per pin (pins 0,1,11,12 -> 0..3)
    localparam logic [1:0] ANA_CH_P0 = 2'h0;
    localparam logic [1:0] ANA_CH_P1 = 2'h1;
    localparam logic [1:0] ANA_CH_P11 = 2'h2;
    localparam logic [1:0] ANA_CH_P12 = 2'h3;

    // host configuration command
    typedef struct packed {
        logic valid;
        logic [3:0] pin;
        logic [3:0] code;
    } cfg_cmd_type;

    // status indication sources
    typedef struct packed {
        logic dir;
        logic busy;
        logic first_window_open_flag;
        logic second_window_open_flag;
        logic doze_state_flag;
        logic receive_lamp;
        logic transmit_lamp;
    } ind_src_type;

    // primary peripheral signals toward the pins
    typedef struct packed {
        logic serial_attention_out;
        logic serial_busy_out;
        logic serial_select_master;
        logic serial_clock_out;
        logic serial_data_out;
        logic uart_one_transmit;
        logic uart_zero_transmit;
        logic is_master;
    } periph_out_type;

    // primary peripheral signals from the pins
    typedef struct packed {
        logic serial_data_in;
        logic serial_clock_in;
        logic serial_select_slave;
        logic sleep_request;
        logic uart_one_receive;
        logic uart_zero_receive;
        logic twowire_data_in;
        logic twowire_clock_in;
    } periph_in_type;

    function automatic logic code_ok(input logic [3:0] pin,
                                     input logic [3:0] code);
        logic ok;
        ok = 1'b0;
        unique case (code)
            FN_DISABLE, FN_LOW, FN_HIGH: ok = 1'b1;
            FN_MAIN: ok = CAP_MAIN[pin];
            FN_ANALOG: ok = CAP_ANALOG[pin];
            FN_FLOAT: ok = CAP_FLOAT[pin];
            FN_PULLUP: ok = CAP_PULLUP[pin];
            FN_IND_TRUE, FN_IND_INV: ok = CAP_IND[pin];
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic [3:0] reset_code(input int pin);
        return CAP_PULLUP[pin] ? FN_PULLUP : RST_NO_PULL;
    endfunction
endpackage

/* File: design/pin_code_store.sv */
// per-pin function code storage with registered read port
`timescale 1ns/10ps
module pin_code_store
    import pin_select_pkg::*;
#(
    parameter int DEPTH = PIN_COUNT
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // async reset, high
    input wire logic clk_en, // freezes state when low
    input wire logic wr_en, // write strobe
    input wire logic [3:0] wr_pin, // write index
    input wire logic [3:0] wr_code, // write data
    output logic [DEPTH*CODE_W-1:0] codes_q // all codes, registered
);
    // one register per pin; reset picks the documented default
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_pin
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    codes_q[g*CODE_W +: CODE_W] <= reset_code(g);
                end else if (clk_en && wr_en && wr_pin == 4'(g)) begin
                    codes_q[g*CODE_W +: CODE_W] <= wr_code;
                end
            end
        end
    endgenerate
endmodule

/* File: design/dio_pin_function_select.sv */
// general pin function selector top
`timescale 1ns/10ps
module dio_pin_function_select
    import pin_select_pkg::*;
(
    input wire logic clk, // system clock, 25 MHz
    input wire logic sys_rst, // async reset, high
    input wire logic clk_en, // freezes state when low
    input cfg_cmd_type cfg_cmd, // host configuration command
    output logic cfg_ack_q, // pulse: command accepted
    output logic cfg_nak_q, // pulse: command rejected
    input wire logic rd_req, // host level read request
    input wire logic [3:0] rd_pin, // pin to read
    output logic rd_valid_q, // pulse: read answer ready
    output logic rd_ok_q, // pin was in an input mode
    output logic rd_level_q, // sampled pin level
    input wire logic [1:0] adc_ch, // analog channel to read
    input wire logic adc_req, // analog read request
    input wire logic [ADC_W-1:0] adc_raw, // converter result, channel adc_ch
    output logic adc_valid_q, // pulse: analog answer ready
    output logic adc_ok_q, // channel's pin in analog mode
    output logic [ADC_W-1:0] adc_data_q, // conversion result
    input ind_src_type ind_src, // indication conditions
    input periph_out_type periph_out, // peripheral to pins
    output periph_in_type periph_in_q, // pins to peripheral
    input wire logic [15:0] general_pin_n_in, // pin levels
    output logic [15:0] general_pin_n_out_q, // pin drive values
    output logic [15:0] general_pin_n_oe_q, // pin drive enables
    output logic [15:0] pull_up_en_q, // pull-up enables
    output logic [3:0] analog_sel_q // analog switch per channel
);
    logic [PIN_COUNT*CODE_W-1:0] codes;
    logic accept;
    logic [15:0] main_val;
    logic [15:0] ind_val;
    logic [15:0] out_d;
    logic [15:0] oe_d;
    logic [15:0] pu_d;
    logic [15:0] in_mode;
    logic [3:0] ana_d;
    logic [3:0] ana_pin [4];
    periph_in_type pin_d;

    // a bad code must not disturb the stored one
    assign accept = cfg_cmd.valid &&
        code_ok(cfg_cmd.pin, cfg_cmd.code);

    pin_code_store #(
        .DEPTH(PIN_COUNT)
    ) u_store (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .wr_en(accept),
        .wr_pin(cfg_cmd.pin),
        .wr_code(cfg_cmd.code),
        .codes_q(codes)
    );

    // command answer pulses
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ack_q <= 1'b0;
            cfg_nak_q <= 1'b0;
        end else if (clk_en) begin
            cfg_ack_q <= accept;
            cfg_nak_q <= cfg_cmd.valid && !accept;
        end
    end

    // fixed primary mapping; undriven main pins stay zero
    always_comb begin
        main_val = 16'h0000;
        main_val[0] = periph_out.serial_attention_out;
        main_val[1] = periph_out.serial_busy_out;
        main_val[2] = periph_out.serial_select_master;
        main_val[5] = periph_out.serial_clock_out;
        main_val[7] = periph_out.uart_one_transmit;
        main_val[14] = periph_out.uart_zero_transmit;
    end

    // fixed indication sources per pin
    always_comb begin
        ind_val = 16'h0000;
        ind_val[0] = ind_src.dir;
        ind_val[1] = ind_src.busy;
        ind_val[2] = ind_src.first_window_open_flag;
        ind_val[3] = ind_src.dir;
        ind_val[4] = ind_src.doze_state_flag;
        ind_val[5] = ind_src.second_window_open_flag;
        ind_val[11] = ind_src.receive_lamp;
        ind_val[12] = ind_src.transmit_lamp;
    end

    // per-pin drive, enable and pull decoding
    always_comb begin
        out_d = 16'h0000;
        oe_d = 16'h0000;
        pu_d = 16'h0000;
        in_mode = 16'h0000;
        for (int i = 0; i < PIN_COUNT; i++) begin
            unique case (codes[i*CODE_W +: CODE_W])
                FN_DISABLE: begin
                    oe_d[i] = 1'b0;
                end
                FN_MAIN: begin
                    // spi data direction flips with the master/slave role
                    if (i == 3) begin
                        oe_d[i] = periph_out.is_master;
                        out_d[i] = periph_out.serial_data_out;
                    end else if (i == 4) begin
                        oe_d[i] = !periph_out.is_master;
                        out_d[i] = periph_out.serial_data_out;
                    end else if (i == 5) begin
                        oe_d[i] = periph_out.is_master;
                        out_d[i] = main_val[i];
                    end else if (i == 2) begin
                        oe_d[i] = periph_out.is_master;
                        out_d[i] = main_val[i];
                    end else begin
                        oe_d[i] = MAIN_DRIVES[i];
                        out_d[i] = main_val[i];
                    end
                end
                FN_ANALOG: begin
                    oe_d[i] = 1'b0;
                end
                FN_FLOAT: begin
                    in_mode[i] = 1'b1;
                end
                FN_PULLUP: begin
                    in_mode[i] = 1'b1;
                    pu_d[i] = CAP_PULLUP[i];
                end
                FN_LOW: begin
                    oe_d[i] = 1'b1;
                end
                FN_HIGH: begin
                    oe_d[i] = 1'b1;
                    out_d[i] = 1'b1;
                end
                FN_IND_TRUE: begin
                    // indication 0 pulls the pin low while its condition holds
                    oe_d[i] = 1'b1;
                    out_d[i] = !ind_val[i];
                end
                FN_IND_INV: begin
                    oe_d[i] = 1'b1;
                    out_d[i] = ind_val[i];
                end
                default: begin
                    oe_d[i] = 1'b0; // pull-down never stored
                end
            endcase
        end
    end

    // analog switch enables per channel
    assign ana_pin[0] = 4'h0;
    assign ana_pin[1] = 4'h1;
    assign ana_pin[2] = 4'hB;
    assign ana_pin[3] = 4'hC;
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            ana_d[c] = codes[ana_pin[c]*CODE_W +: CODE_W] == FN_ANALOG;
        end
    end

    // pins toward peripherals only when in main mode
    always_comb begin
        pin_d = '0;
        if (codes[3*CODE_W +: CODE_W] == FN_MAIN && !periph_out.is_master)
            pin_d.serial_data_in = general_pin_n_in[3];
        if (codes[4*CODE_W +: CODE_W] == FN_MAIN && periph_out.is_master)
            pin_d.serial_data_in = general_pin_n_in[4];
        if (codes[5*CODE_W +: CODE_W] == FN_MAIN)
            pin_d.serial_clock_in = general_pin_n_in[5];
        if (codes[10*CODE_W +: CODE_W] == FN_MAIN) begin
            pin_d.serial_select_slave = general_pin_n_in[10];
            pin_d.sleep_request = general_pin_n_in[10];
        end
        if (codes[6*CODE_W +: CODE_W] == FN_MAIN)
            pin_d.uart_one_receive = general_pin_n_in[6];
        if (codes[13*CODE_W +: CODE_W] == FN_MAIN)
            pin_d.uart_zero_receive = general_pin_n_in[13];
        if (codes[8*CODE_W +: CODE_W] == FN_MAIN)
            pin_d.twowire_data_in = general_pin_n_in[8];
        if (codes[9*CODE_W +: CODE_W] == FN_MAIN)
            pin_d.twowire_clock_in = general_pin_n_in[9];
    end

    // registered pin outputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            general_pin_n_out_q <= 16'h0000;
            general_pin_n_oe_q <= 16'h0000;
            pull_up_en_q <= 16'h0000;
            analog_sel_q <= 4'h0;
            periph_in_q <= '0;
        end else if (clk_en) begin
            general_pin_n_out_q <= out_d;
            general_pin_n_oe_q <= oe_d;
            pull_up_en_q <= pu_d;
            analog_sel_q <= ana_d;
            periph_in_q <= pin_d;
        end
    end

    // host level read; refused unless pin is an input
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_valid_q <= 1'b0;
            rd_ok_q <= 1'b0;
            rd_level_q <= 1'b0;
        end else if (clk_en) begin
            rd_valid_q <= rd_req;
            if (rd_req) begin
                rd_ok_q <= in_mode[rd_pin];
                rd_level_q <= in_mode[rd_pin] & general_pin_n_in[rd_pin];
            end
        end
    end

    // analog read; data only when channel's pin is analog
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            adc_valid_q <= 1'b0;
            adc_ok_q <= 1'b0;
            adc_data_q <= '0;
        end else if (clk_en) begin
            adc_valid_q <= adc_req;
            if (adc_req) begin
                adc_ok_q <= ana_d[adc_ch];
                adc_data_q <= ana_d[adc_ch] ? adc_raw : '0;
            end
        end
    end

    // checks
    a_reject_keeps: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && cfg_cmd.valid && !accept |=> $stable(codes))
        else $error("rejected command changed a code");
    a_nopull_pins: assert property (@(posedge clk)
        disable iff (sys_rst)
        (pull_up_en_q & 16'h1803) == 16'h0000)
        else $error("pull-up on pin without pull-up");
    a_fixed_high: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && codes[7*CODE_W +: CODE_W] == FN_HIGH |=>
        general_pin_n_oe_q[7] && general_pin_n_out_q[7])
        else $error("fixed high not driven");
    a_disable_quiet: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && codes[15*CODE_W +: CODE_W] == FN_DISABLE |=>
        !general_pin_n_oe_q[15])
        else $error("disabled pin driven");
    a_ind_invert: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && codes[12*CODE_W +: CODE_W] == FN_IND_TRUE |=>
        general_pin_n_out_q[12] == !$past(ind_src.transmit_lamp))
        else $error("inverted indication wrong");
    a_ind_active: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && codes[11*CODE_W +: CODE_W] == FN_IND_INV |=>
        general_pin_n_out_q[11] == $past(ind_src.receive_lamp))
        else $error("active-high indication wrong");
    a_ack_write: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && accept |=> cfg_ack_q &&
        codes[$past(cfg_cmd.pin)*CODE_W +: CODE_W] == $past(cfg_cmd.code))
        else $error("accepted code not stored");
    a_read_refuse: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && rd_req && !in_mode[rd_pin] |=> rd_valid_q && !rd_ok_q)
        else $error("read of non-input pin accepted");
    a_no_pulldown: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && cfg_cmd.valid && cfg_cmd.code == FN_PULLDOWN |=> cfg_nak_q)
        else $error("pull-down code accepted");

    // every taken command gets exactly one answer on the next edge
    sequence s_cmd_taken;
        clk_en && cfg_cmd.valid;
    endsequence
    sequence s_one_answer;
        cfg_ack_q != cfg_nak_q;
    endsequence
    a_cmd_answer: assert property (@(posedge clk)
        disable iff (sys_rst)
        s_cmd_taken |=> s_one_answer)
        else $error("command not answered exactly once");

    // a frozen edge must leave codes and drive enables alone
    a_frozen_hold: assert property (@(posedge clk)
        disable iff (sys_rst)
        !clk_en |=> $stable(codes) && $stable(general_pin_n_oe_q))
        else $error("state moved while frozen");

    // pin 10 feeds both slave select and sleep request in main mode
    a_slave_select: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && codes[10*CODE_W +: CODE_W] == FN_MAIN |=>
        periph_in_q.serial_select_slave == $past(general_pin_n_in[10]) &&
        periph_in_q.sleep_request == $past(general_pin_n_in[10]))
        else $error("slave select not routed");

    // a channel whose pin is not analog answers with zero data
    a_adc_refuse: assert property (@(posedge clk)
        disable iff (sys_rst)
        clk_en && adc_req && !ana_d[adc_ch] |=>
        adc_valid_q && !adc_ok_q && adc_data_q == '0)
        else $error("analog read of non-analog channel accepted");
endmodule

/* File: testbench/pin_load_model.sv */
// pin loads and external drivers seen at the general pins
`timescale 1ns/10ps
module pin_load_model (
    input wire logic clk, // system clock
    input wire logic [15:0] oe, // device drive enables
    input wire logic [15:0] drv, // device drive values
    input wire logic [15:0] pu, // device pull-up enables
    input wire logic [15:0] ext_drv, // far side drives the pin
    input wire logic [15:0] ext_val, // far side drive value
    output logic [15:0] level // resolved pin level
);
    logic [15:0] last_q = 16'h0000;

    // device drive wins; a released line with no pull flips every cycle
    // so a stale value is never mistaken for a real level
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (oe[i]) begin
                level[i] = drv[i];
            end else if (ext_drv[i]) begin
                level[i] = ext_val[i];
            end else if (pu[i]) begin
                level[i] = 1'b1;
            end else begin
                level[i] = ~last_q[i];
            end
        end
    end

    // memory of the last level for the floating pattern
    always_ff @(posedge clk) begin
        last_q <= level;
    end
endmodule

/* File: testbench/dio_pin_function_select_bench.sv */
// self-checking bench for the general pin function selector
`timescale 1ns/10ps
module dio_pin_function_select_bench;
    import pin_select_pkg::*;
    localparam logic [15:0] ALW = 16'h4083;
    localparam logic [15:0] MST = 16'h002C;
    localparam logic [15:0] SLV = 16'h0010;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    cfg_cmd_type cfg_cmd = '0;
    logic rd_req = 1'b0;
    logic [3:0] rd_pin = 4'h0;
    logic [1:0] adc_ch = 2'h0;
    logic adc_req = 1'b0;
    logic [ADC_W-1:0] adc_raw = '0;
    ind_src_type ind_src = '0;
    periph_out_type periph_out = '0;
    logic [15:0] ext_val = 16'h0000;
    logic [15:0] ext_drv = 16'h0000;
    logic [15:0] pin_lvl, pin_out, pin_oe, pull_up;
    logic cfg_ack_q, cfg_nak_q, rd_valid_q, rd_ok_q, rd_level_q;
    logic adc_valid_q, adc_ok_q;
    logic [ADC_W-1:0] adc_data_q;
    periph_in_type periph_in_q;
    logic [3:0] analog_sel_q;
    logic [3:0] codes [16];
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    dio_pin_function_select dio_pin_function_select_inst (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cfg_cmd(cfg_cmd),
        .cfg_ack_q(cfg_ack_q), .cfg_nak_q(cfg_nak_q), .rd_req(rd_req),
        .rd_pin(rd_pin), .rd_valid_q(rd_valid_q), .rd_ok_q(rd_ok_q),
        .rd_level_q(rd_level_q), .adc_ch(adc_ch), .adc_req(adc_req),
        .adc_raw(adc_raw), .adc_valid_q(adc_valid_q), .adc_ok_q(adc_ok_q),
        .adc_data_q(adc_data_q), .ind_src(ind_src),
        .periph_out(periph_out), .periph_in_q(periph_in_q),
        .general_pin_n_in(pin_lvl), .general_pin_n_out_q(pin_out),
        .general_pin_n_oe_q(pin_oe), .pull_up_en_q(pull_up),
        .analog_sel_q(analog_sel_q));

    pin_load_model pin_load_model_inst (.clk(clk), .oe(pin_oe),
        .drv(pin_out), .pu(pull_up), .ext_drv(ext_drv),
        .ext_val(ext_val), .level(pin_lvl));

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, the run needs about 1250 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            finish_test();
        end
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // which codes a pin accepts, from the capability masks
    function automatic logic acc_ok(input int p, input logic [3:0] c);
        case (c)
            FN_DISABLE, FN_LOW, FN_HIGH: return 1'b1;
            FN_MAIN: return CAP_MAIN[p];
            FN_ANALOG: return CAP_ANALOG[p];
            FN_FLOAT: return CAP_FLOAT[p];
            FN_PULLUP: return CAP_PULLUP[p];
            FN_IND_TRUE, FN_IND_INV: return CAP_IND[p];
            default: return 1'b0;
        endcase
    endfunction

    // fixed indication source of each pin
    function automatic logic ind_of(input int p);
        case (p)
            0, 3: return ind_src.dir;
            1: return ind_src.busy;
            2: return ind_src.first_window_open_flag;
            5: return ind_src.second_window_open_flag;
            4: return ind_src.doze_state_flag;
            11: return ind_src.receive_lamp;
            default: return ind_src.transmit_lamp;
        endcase
    endfunction

    // main output value of every pin that drives in main mode
    function automatic logic main_of(input int p);
        case (p)
            0: return periph_out.serial_attention_out;
            1: return periph_out.serial_busy_out;
            2: return periph_out.serial_select_master;
            3, 4: return periph_out.serial_data_out;
            5: return periph_out.serial_clock_out;
            7: return periph_out.uart_one_transmit;
            default: return periph_out.uart_zero_transmit;
        endcase
    endfunction

    // reset, then the documented defaults must show at the pins
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (3) tick();
        sys_rst = 1'b0;
        for (int p = 0; p < 16; p++) begin
            codes[p] = CAP_PULLUP[p] ? FN_PULLUP : FN_LOW;
        end
        tick();
        chk_vec(pull_up, 16'hE7FC);
        chk_vec(pin_oe, 16'h1803);
        chk_vec(pin_out, 16'h0000);
    endtask

    // one command; valid stays up so calls may run back to back
    task automatic cfg(input logic [3:0] p, input logic [3:0] c);
        logic ok;
        ok = acc_ok(p, c);
        cfg_cmd = '{valid: 1'b1, pin: p, code: c};
        tick();
        chk_bit(cfg_ack_q, ok);
        chk_bit(cfg_nak_q, ~ok);
        if (ok) codes[p] = c;
    endtask

    task automatic check_pins();
        logic [15:0] oe, out, msk, pu;
        cfg_cmd.valid = 1'b0;
        repeat (3) tick();
        oe = '0;
        out = '0;
        msk = '0;
        pu = '0;
        for (int p = 0; p < 16; p++) begin
            case (codes[p])
                FN_MAIN: begin
                    oe[p] = periph_out.is_master ? (ALW[p] | MST[p])
                                                 : (ALW[p] | SLV[p]);
                    msk[p] = oe[p];
                    out[p] = main_of(p);
                end
                FN_PULLUP: pu[p] = 1'b1;
                FN_LOW, FN_HIGH, FN_IND_TRUE, FN_IND_INV: begin
                    oe[p] = 1'b1;
                    msk[p] = 1'b1;
                    // indication 0 is low while active, indication 1 high
                    out[p] = codes[p][3] ? (codes[p][0] ~^ ind_of(p))
                                         : codes[p][0];
                end
                default: ;
            endcase
        end
        chk_vec(pin_oe, oe);
        chk_vec(pin_out & msk, out & msk);
        chk_vec(pull_up, pu);
        chk_vec({12'h000, analog_sel_q}, {12'h000, codes[12] == FN_ANALOG,
            codes[11] == FN_ANALOG, codes[1] == FN_ANALOG,
            codes[0] == FN_ANALOG});
        if (ext_drv[6] || codes[6] != FN_MAIN)
            chk_bit(periph_in_q.uart_one_receive,
                codes[6] == FN_MAIN && ext_val[6]);
        if (ext_drv[10] || codes[10] != FN_MAIN) begin
            chk_bit(periph_in_q.serial_select_slave,
                codes[10] == FN_MAIN && ext_val[10]);
            chk_bit(periph_in_q.sleep_request,
                codes[10] == FN_MAIN && ext_val[10]);
        end
        if (ext_drv[13] || codes[13] != FN_MAIN)
            chk_bit(periph_in_q.uart_zero_receive,
                codes[13] == FN_MAIN && ext_val[13]);
        if (ext_drv[8] || codes[8] != FN_MAIN)
            chk_bit(periph_in_q.twowire_data_in,
                codes[8] == FN_MAIN && ext_val[8]);
    endtask

    task automatic rd_check(input logic [3:0] p);
        logic ok;
        ok = codes[p] == FN_FLOAT || codes[p] == FN_PULLUP;
        rd_req = 1'b1;
        rd_pin = p;
        tick();
        rd_req = 1'b0;
        chk_bit(rd_valid_q, 1'b1);
        chk_bit(rd_ok_q, ok);
        if (!ok) chk_bit(rd_level_q, 1'b0);
        else if (ext_drv[p]) chk_bit(rd_level_q, ext_val[p]);
        else if (codes[p] == FN_PULLUP) chk_bit(rd_level_q, 1'b1);
    endtask

    task automatic adc_check(input logic [1:0] ch);
        logic [3:0] p;
        logic ok;
        logic [11:0] raw;
        p = (ch == 2'h0) ? 4'h0 : (ch == 2'h1) ? 4'h1
          : (ch == 2'h2) ? 4'hB : 4'hC;
        raw = 12'($urandom);
        ok = codes[p] == FN_ANALOG;
        adc_req = 1'b1;
        adc_ch = ch;
        adc_raw = raw;
        tick();
        adc_req = 1'b0;
        chk_bit(adc_valid_q, 1'b1);
        chk_bit(adc_ok_q, ok);
        chk_vec({4'h0, adc_data_q}, ok ? {4'h0, raw} : 16'h0000);
    endtask

    initial begin
        void'($urandom(32'hB60E6035));
        do_reset();
        // frozen enable: a command must get no answer at all
        clk_en = 1'b0;
        cfg_cmd = '{valid: 1'b1, pin: 4'h3, code: FN_HIGH};
        tick();
        chk_bit(cfg_ack_q | cfg_nak_q, 1'b0);
        clk_en = 1'b1;
        cfg(4'hF, FN_PULLDOWN);
        cfg(4'h0, FN_PULLUP);
        cfg(4'hB, 4'hC);
        cfg(4'h1, FN_ANALOG);
        cfg(4'hC, FN_ANALOG);
        // every code back to back on one pin, ends on a refused code
        for (int c = 0; c < 16; c++) cfg(4'h4, 4'(c));
        check_pins();
        adc_check(2'h1);
        rd_check(4'h2);
        adc_check(2'h3);
        // both indication polarities, slave select, fixed high, disabled
        cfg(4'hC, FN_IND_TRUE);
        cfg(4'hB, FN_IND_INV);
        cfg(4'hA, FN_MAIN);
        cfg(4'h7, FN_HIGH);
        cfg(4'hF, FN_DISABLE);
        ind_src = 7'h7F;
        check_pins();
        for (int i = 0; i < 200; i++) begin
            if (i == 100) do_reset();
            ind_src = 7'($urandom);
            periph_out = 8'($urandom);
            ext_val = 16'($urandom);
            ext_drv = 16'($urandom);
            cfg(4'($urandom), 4'($urandom));
            check_pins();
            rd_check(4'($urandom));
            adc_check(2'($urandom));
        end
        finish_test();
    end
endmodule
